// ---- hdl/pfi_pkg.sv ----
// package for the fault interrupt mask and suspend status block
package pfi_pkg;
    localparam logic [7:0] ADDR_MASK_LDO_V   = 8'h17;
    localparam logic [7:0] ADDR_MASK_SW_V   = 8'h18;
    localparam logic [7:0] ADDR_MASK_PEAK   = 8'h19;
    localparam logic [7:0] ADDR_SUSPEND     = 8'h1A;
    localparam logic [7:0] MASK_RESET       = 8'h00;
    localparam logic [7:0] SUSPEND_RESET    = 8'h00;
    localparam logic [7:0] READ_IDLE        = 8'h00;
    localparam int         NUM_EVENTS       = 24;
    localparam int         SUSP_UNUSED_BIT  = 7;

    // register access request from the serial control bus core
    typedef struct packed {
        logic       wrStrobe;
        logic       rdStrobe;
        logic [7:0] addr;
        logic [7:0] wrData;
    } pfi_req_s;

    // per unit suspend causes, bit order matches the status register
    typedef struct packed {
        logic       chip;
        logic       boost;
        logic       buck;
        logic [3:0] reg4to1;
    } pfi_susp_s;
endpackage

// ---- hdl/pfi_irq_mask.sv ----
// fault interrupt masking and suspend status registers
//
// Contract
// R1: first mask: bits7-4 reg OV, 3-0 UV
// R2: mask 0 passes event, 1 blocks it
// R3: second mask bits7-4 switcher OV/UV
// R4: second mask bits3-0 regulator overcurrent
// R5: third mask bits7-6 peak current
// R6: third mask bits5-2 input lockouts
// R7: third mask bit1 shutdown, bit0 warning
// R8: suspend bit6 whole chip suspended
// R9: suspend bits5/4 boost and buck
// R10: suspend bits3-0 regulators 4 to 1
// R11: suspend read-only, reset 0, bit7 unused
// R12: flags latched elsewhere, cleared by read
// R13: live status kept outside, no latching
// R14: irq low when unmasked flag set
// R15: all masks reset to zero
`timescale 1ns/1ps
`default_nettype none
module pfi_irq_mask
    import pfi_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // register access from the serial bus core
    input  wire pfi_req_s              req,
    output var  logic [7:0]            rdData,
    output var  logic                  rdValid,
    // latched interrupt flags, same bit order as the three masks
    input  wire logic [NUM_EVENTS-1:0] irqFlags,
    // suspend causes from the sequencer
    input  wire logic [6:0]            suspendIn,
    // interrupt pin, active low
    output var  logic                  irq_out_n
);
    logic [7:0]            irqMaskLdoVoltage;
    logic [7:0]            irqMaskSwitcherVoltageLdoCurrent;
    logic [7:0]            irqMaskPeakInputThermal;
    logic [7:0]            suspendState;
    logic [NUM_EVENTS-1:0] maskAll;
    logic [NUM_EVENTS-1:0] passed;
    logic [7:0]            next_rdData;
    pfi_susp_s             suspCause;

    // mask registers, written from the bus, reset to unmasked
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqMaskLdoVoltage                <= MASK_RESET; // [R15]
            irqMaskSwitcherVoltageLdoCurrent <= MASK_RESET; // [R15]
            irqMaskPeakInputThermal          <= MASK_RESET; // [R15]
        end else if (req.wrStrobe) begin
            case (req.addr)
                ADDR_MASK_LDO_V: irqMaskLdoVoltage <= req.wrData; // [R1]
                ADDR_MASK_SW_V:  irqMaskSwitcherVoltageLdoCurrent <= req.wrData; // [R3] [R4]
                ADDR_MASK_PEAK:  irqMaskPeakInputThermal <= req.wrData; // [R5] [R6] [R7]
                default: begin
                end
            endcase
        end
    end

    // suspend causes viewed as named units
    assign suspCause = suspendIn; // [R8] [R9] [R10]

    // suspend status register mirrors the causes live, top bit held zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            suspendState <= SUSPEND_RESET; // [R11]
        end else begin
            suspendState <= {1'b0, suspCause}; // [R8] [R9] [R10] [R11] [R13]
        end
    end

    // per event gating of flags by mask bits
    assign maskAll = {irqMaskPeakInputThermal, irqMaskSwitcherVoltageLdoCurrent, irqMaskLdoVoltage};
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi++) begin : gEvt
            assign passed[gi] = irqFlags[gi] & ~maskAll[gi]; // [R2] [R12]
        end
    endgenerate

    // interrupt pin driven low on any unmasked flag
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= ~(|passed); // [R14]
        end
    end

    // read data mux, writes to the status register are ignored
    always_comb begin
        case (req.addr)
            ADDR_MASK_LDO_V: next_rdData = irqMaskLdoVoltage;
            ADDR_MASK_SW_V:  next_rdData = irqMaskSwitcherVoltageLdoCurrent;
            ADDR_MASK_PEAK:  next_rdData = irqMaskPeakInputThermal;
            ADDR_SUSPEND:    next_rdData = suspendState; // [R11]
            default:         next_rdData = READ_IDLE;
        endcase
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdData  <= READ_IDLE;
            rdValid <= 1'b0;
        end else begin
            rdValid <= req.rdStrobe;
            rdData  <= req.rdStrobe ? next_rdData : READ_IDLE;
        end
    end

    // checks: interrupt pin
    sequence s_unmaskedFlag;
        |passed;
    endsequence

    sequence s_allMasked;
        &maskAll;
    endsequence

    property p_irqFollows;
        @(posedge clk) disable iff (!rst_b)
        s_unmaskedFlag |=> !irq_out_n;
    endproperty

    a_irq_asserts: assert property (p_irqFollows) // [R14]
        else $error("irq pin not low after unmasked flag");

    a_irq_release: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
        !(|(irqFlags & ~maskAll)) |=> irq_out_n)
        else $error("irq pin low with no unmasked flag");

    a_irq_masked: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
        s_allMasked |=> irq_out_n)
        else $error("irq pin low with every event masked");

    // checks: mask registers
    sequence s_wrLdo;
        req.wrStrobe && req.addr == ADDR_MASK_LDO_V;
    endsequence

    sequence s_wrSwitcher;
        req.wrStrobe && req.addr == ADDR_MASK_SW_V;
    endsequence

    sequence s_wrStatus;
        req.wrStrobe && req.addr == ADDR_SUSPEND;
    endsequence

    a_mask_write: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
        req.wrStrobe && req.addr == ADDR_MASK_PEAK |=> irqMaskPeakInputThermal == $past(req.wrData))
        else $error("third mask not written");

    a_ldo_write: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        s_wrLdo |=> irqMaskLdoVoltage == $past(req.wrData))
        else $error("first mask not written");

    a_sw_write: assert property (@(posedge clk) disable iff (!rst_b) // [R3] [R4]
        s_wrSwitcher |=> irqMaskSwitcherVoltageLdoCurrent == $past(req.wrData))
        else $error("second mask not written");

    a_mask_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        !req.wrStrobe |=> $stable(irqMaskLdoVoltage))
        else $error("first mask changed without write");

    a_status_ro: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
        s_wrStatus |=> $stable(irqMaskLdoVoltage) && $stable(irqMaskSwitcherVoltageLdoCurrent)
            && $stable(irqMaskPeakInputThermal))
        else $error("status write disturbed a mask");

    // checks: read answers
    a_read_ans: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
        req.rdStrobe && req.addr == ADDR_MASK_SW_V
        |=> rdValid && rdData == $past(irqMaskSwitcherVoltageLdoCurrent))
        else $error("second mask read wrong");

    a_ldo_read: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        req.rdStrobe && req.addr == ADDR_MASK_LDO_V |=> rdValid && rdData == $past(irqMaskLdoVoltage))
        else $error("first mask read wrong");

    a_peak_read: assert property (@(posedge clk) disable iff (!rst_b) // [R5] [R6] [R7]
        req.rdStrobe && req.addr == ADDR_MASK_PEAK |=> rdValid && rdData == $past(irqMaskPeakInputThermal))
        else $error("third mask read wrong");

    a_susp_read: assert property (@(posedge clk) disable iff (!rst_b) // [R9] [R10]
        req.rdStrobe && req.addr == ADDR_SUSPEND |=> rdValid && rdData == $past(suspendState))
        else $error("suspend status read wrong");

    a_susp_unused: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
        rdValid && $past(req.addr) == ADDR_SUSPEND |-> !rdData[SUSP_UNUSED_BIT])
        else $error("suspend top bit not zero");

    a_no_answer: assert property (@(posedge clk) disable iff (!rst_b)
        !req.rdStrobe |=> !rdValid && rdData == READ_IDLE)
        else $error("read answer without a strobe");

    a_unmapped_rd: assert property (@(posedge clk) disable iff (!rst_b)
        req.rdStrobe && req.addr > ADDR_SUSPEND |=> rdValid && rdData == READ_IDLE)
        else $error("unmapped read not zero");

    // checks: suspend status
    sequence s_noCause;
        !(|suspendIn);
    endsequence

    a_susp_track: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
        1'b1 |=> suspendState[SUSP_UNUSED_BIT-1:0] == $past(suspendIn))
        else $error("suspend status lags cause");

    a_susp_live: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        s_noCause |=> suspendState == SUSPEND_RESET)
        else $error("suspend status held after cause dropped");

    // checks: reset
    a_reset_mask: assert property (@(posedge clk) // [R15]
        !rst_b |=> irqMaskLdoVoltage == MASK_RESET && irq_out_n)
        else $error("mask not cleared by reset");

    a_reset_all: assert property (@(posedge clk) // [R15] [R11]
        !rst_b |=> irqMaskSwitcherVoltageLdoCurrent == MASK_RESET && irqMaskPeakInputThermal == MASK_RESET
            && suspendState == SUSPEND_RESET)
        else $error("mask or status not cleared by reset");
endmodule
`default_nettype wire

// ---- test/pfi_host_model.sv ----
// host side model that captures read answers
`timescale 1ns/1ps
`default_nettype none
module pfi_host_model (
    // clock
    input  wire logic       clk,
    // read answer from the device
    input  wire logic [7:0] rdData,
    input  wire logic       rdValid,
    // last byte taken
    output var  logic [7:0] lastRead
);
    // take the byte at the edge where the answer stands
    always_ff @(posedge clk) begin
        if (rdValid) begin
            lastRead <= rdData;
        end
    end
endmodule
`default_nettype wire

// ---- test/pfi_irq_mask_tb.sv ----
// self-checking bench for the fault mask block
`timescale 1ns/1ps
`default_nettype none
module pfi_irq_mask_tb;
    import pfi_pkg::*;
    logic clk = 0, rst_b = 0, rdValid, irqN;
    pfi_req_s req = '0;
    logic [NUM_EVENTS-1:0] flags = '0;
    logic [6:0] susp = '0;
    logic [7:0] rdData, lastRead, v;
    logic [7:0] m [3];
    int bad_count = 0, compares = 0, cyc = 0;
    // clock
    initial forever #2.5 clk = ~clk;
    pfi_irq_mask dut_u (.clk(clk), .rst_b(rst_b), .req(req), .rdData(rdData), .rdValid(rdValid),
        .irqFlags(flags), .suspendIn(susp), .irq_out_n(irqN));
    pfi_host_model host_u (.clk(clk), .rdData(rdData), .rdValid(rdValid), .lastRead(lastRead));
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            bad_count++;
            summarize();
        end
    end
    // compare a byte result
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // compare a single level result
    task automatic chkBit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t level got %b want %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req.wrStrobe = 1;
        req.addr = a;
        req.wrData = d;
        @(negedge clk);
        req.wrStrobe = 0;
    endtask
    // read: answer stands one cycle after the strobe, then the port idles
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        req.rdStrobe = 1;
        req.addr = a;
        @(negedge clk);
        req.rdStrobe = 0;
        chkBit(rdValid, 1'b1);
        @(negedge clk);
        chkBit(rdValid, 1'b0);
        chk(rdData, READ_IDLE);
        chk(lastRead, exp);
    endtask
    task automatic pin(input logic exp);
        repeat (3) @(negedge clk);
        chkBit(irqN, exp);
    endtask
    task automatic summarize();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        v = $urandom(32'h721E);
        repeat (8) @(negedge clk);
        rst_b = 1;
        for (int r = 0; r < 3; r++) rd(ADDR_MASK_LDO_V + 8'(r), MASK_RESET);
        rd(ADDR_SUSPEND, SUSPEND_RESET);
        pin(1'b1);
        for (int i = 0; i < NUM_EVENTS; i++) begin
            for (int r = 0; r < 3; r++) begin
                m[r] = 8'($urandom);
                wr(ADDR_MASK_LDO_V + 8'(r), m[r]);
            end
            flags = 24'h000001 << i;
            pin(m[i/8][i%8]);
            rd(ADDR_MASK_LDO_V + 8'(i/8), m[i/8]);
            susp = 7'($urandom);
            wr(ADDR_SUSPEND, 8'hFF);
            rd(ADDR_SUSPEND, {1'b0, susp});
        end
        // mid-run reset puts every mask back to unmasked
        @(negedge clk);
        rst_b = 0;
        repeat (2) @(negedge clk);
        rst_b = 1;
        for (int r = 0; r < 3; r++) rd(ADDR_MASK_LDO_V + 8'(r), MASK_RESET);
        pin(1'b0);
        // all masked, then one event unmasked, then the host clears the flags
        for (int r = 0; r < 3; r++) wr(ADDR_MASK_LDO_V + 8'(r), 8'hFF);
        flags = '1;
        pin(1'b1);
        wr(ADDR_MASK_PEAK, 8'hFE);
        pin(1'b0);
        flags = '0;
        pin(1'b1);
        // suspend status is live, a dropped cause reads back as normal
        susp = '1;
        rd(ADDR_SUSPEND, {1'b0, susp});
        susp = '0;
        rd(ADDR_SUSPEND, SUSPEND_RESET);
        rd(8'h20, READ_IDLE);
        summarize();
    end
endmodule
`default_nettype wire
